// >>> core/trw_pkg.sv
/*
 Package of the tiled-resource translation walker: register offsets,
 field positions, reset values, walk states and the carrier structs.
 Assumes one 250 MHz clock domain shared by every user of the package.
*/
package trw_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_NULL_MATCH = 16'h4de0;
	localparam logic [15:0] OFS_INV_MATCH = 16'h4de4;
	localparam logic [15:0] OFS_ADDR_DETECT = 16'h4de8;
	localparam logic [15:0] OFS_CONTROL = 16'h4dec;
	localparam logic [15:0] OFS_L3_BASE_LO = 16'h4df0;
	localparam logic [15:0] OFS_L3_BASE_HI = 16'h4df4;
	localparam logic [15:0] OFS_NULL_COUNT = 16'h4df8;
	localparam logic [15:0] OFS_BYPASS = 16'h4dfc;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int MASK_LSB = 4;
	localparam int CMP_LSB = 0;
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_LOC_BIT = 1;
	localparam int BYPASS_OFF_BIT = 0;
	localparam int UPPER_NULL_BIT = 1;
	localparam int UPPER_INV_BIT = 0;
	localparam logic [31:0] RST_MATCH = 32'h0000_0000;
	localparam logic [7:0] RST_DETECT = 8'h00;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	localparam logic [35:0] RST_L3_BASE = 36'h0_0000_0000;
	localparam logic [31:0] RST_COUNT = 32'h0000_0000;

	// ------------------------------------------------------------
	// Walk states and answer kinds
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_L3 = 4'h2,
		ST_L2 = 4'h4,
		ST_L1 = 4'h8
	} trw_state_t;

	typedef enum logic [1:0] {
		KIND_PASS = 2'h0,
		KIND_MAPPED = 2'h1,
		KIND_NULL = 2'h2,
		KIND_INVALID = 2'h3
	} trw_kind_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [47:0] addr;
		logic write;
	} trw_req_t;

	typedef struct packed {
		logic valid;
		trw_kind_t kind;
		logic [47:0] addr;
		logic zero_data;
		logic null_ind;
		logic drop;
	} trw_resp_t;

	typedef struct packed {
		logic valid;
		logic [47:0] addr;
		logic virt;
	} trw_fetch_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [31:0] wdata;
	} trw_mmio_req_t;

endpackage : trw_pkg

// >>> core/trw_addr_detect.sv
/*
 Mask and compare of address bits 47:44 against the detect register.
 Assumes a combinational path inside the walker's clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module trw_addr_detect import trw_pkg::*; (
	input wire logic [7:0] detect,
	input wire logic [3:0] addr_top,
	output logic hit
);
	logic [3:0] mask;
	logic [3:0] cmp;

	assign mask = detect[MASK_LSB +: 4];
	assign cmp = detect[CMP_LSB +: 4];
	// All-zero mask disables detection
	assign hit = (mask != 4'h0) && (((addr_top ^ cmp) & mask) == 4'h0);

endmodule : trw_addr_detect

`default_nettype wire

// >>> core/trw_entry_class.sv
/*
 Classifies one fetched tile table entry as null, invalid or resident.
 Assumes the caller picks the 32-bit half for lowest-level entries.
*/
`timescale 1ns/1ns
`default_nettype none

module trw_entry_class import trw_pkg::*; (
	input wire logic leaf,
	input wire logic [63:0] entry,
	input wire logic [31:0] null_val,
	input wire logic [31:0] inv_val,
	output logic is_null,
	output logic is_invalid
);
	always_comb begin
		if (leaf) begin
			is_invalid = (entry[31:0] == inv_val);
			is_null = !is_invalid && (entry[31:0] == null_val);
		end else begin
			is_invalid = entry[UPPER_INV_BIT];
			is_null = !is_invalid && entry[UPPER_NULL_BIT];
		end
	end

endmodule : trw_entry_class

`default_nettype wire

// >>> core/trw_walker.sv
/*
 Tiled-resource translation walker: detects tiled addresses, walks the
 three-level tile tables through the main page walker and answers each
 request as passed, mapped, null or invalid. Registers sit on a simple
 MMIO port. Assumes requesters and the main page walker share clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

// Function
// - Lowest entry equal null value: null tile
// - Lowest entry equal invalid value: invalid tile
// - Mask bits 7:4 select address bits 47:44
// - Compare bits 3:0 match masked address bits
// - Mask only zero (off) or all ones
// - Control bit 1: tables in virtual space; code ignores it, fetch.virt is 1 on every fetch
// - Control bit 0 enables translation, resets zero
// - Bypass off bit at 0x4DFC, default bypassed
// - Null: load returns zero, store dropped
// - Invalid as null, plus interrupt
// - Upper levels use entry flag bits
// - Lowest level compares whole 32-bit entry
// - Null or invalid stops the walk
// - Null access counter readable over MMIO
// - Table fetch faults stay in main walker
// - Unfixed fault gives bad data, no error
// - Nested walk per level, same structure
// - Three levels, 9/9/10 index, 64KB tiles
// - Upper entry bit 1 marks null
// - Upper entry bit 0 marks invalid
module trw_walker import trw_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire trw_req_t req,
	output logic req_ready,
	output trw_resp_t resp,
	output logic tile_fault_irq,
	output trw_fetch_t fetch,
	input wire logic fetch_ready,
	input wire logic fetch_rvalid,
	input wire logic [63:0] fetch_rdata,
	input wire trw_mmio_req_t mmio,
	output logic mmio_ack,
	output logic [31:0] mmio_rdata
);
	typedef struct packed {
		trw_state_t st;
		logic [47:0] addr;
		logic write;
		logic [31:0] null_val;
		logic [31:0] inv_val;
		logic [7:0] detect;
		logic [1:0] ctl;
		logic [35:0] l3_base;
		logic bypass_off;
		logic [31:0] null_count;
		logic req_ready;
		trw_resp_t resp;
		logic irq;
		trw_fetch_t fetch;
		logic mmio_ack;
		logic [31:0] mmio_rdata;
	} trw_walk_state_t;

	trw_walk_state_t s_reg;
	trw_walk_state_t s_next;
	logic hit;
	logic leaf;
	logic got;
	logic [63:0] entry;
	logic cls_null;
	logic cls_inv;
	logic active;

	// ------------------------------------------------------------
	// Detection and entry classification
	// ------------------------------------------------------------
	trw_addr_detect i_trw_addr_detect (
		.detect(s_reg.detect),
		.addr_top(req.addr[47:44]),
		.hit(hit)
	);

	assign leaf = (s_reg.st == ST_L1);
	assign got = fetch_rvalid && !s_reg.fetch.valid && (s_reg.st != ST_IDLE);
	// Lowest level holds two 32-bit entries per qword
	assign entry = (leaf && s_reg.addr[16]) ? {32'h0, fetch_rdata[63:32]} :
		fetch_rdata;

	trw_entry_class i_trw_entry_class (
		.leaf(leaf),
		.entry(entry),
		.null_val(s_reg.null_val),
		.inv_val(s_reg.inv_val),
		.is_null(cls_null),
		.is_invalid(cls_inv)
	);

	assign active = s_reg.ctl[CTL_EN_BIT] && s_reg.bypass_off;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.resp.valid = 1'b0;
		s_next.irq = 1'b0;
		s_next.mmio_ack = 1'b0;

		if (mmio.valid) begin
			s_next.mmio_ack = 1'b1;
			s_next.mmio_rdata = 32'h0;
			case (mmio.addr)
				OFS_NULL_MATCH: s_next.mmio_rdata = s_reg.null_val;
				OFS_INV_MATCH: s_next.mmio_rdata = s_reg.inv_val;
				OFS_ADDR_DETECT: s_next.mmio_rdata = {24'h0, s_reg.detect};
				OFS_CONTROL: s_next.mmio_rdata = {30'h0, s_reg.ctl};
				OFS_L3_BASE_LO: s_next.mmio_rdata = {s_reg.l3_base[19:0], 12'h0};
				OFS_L3_BASE_HI: s_next.mmio_rdata = {16'h0, s_reg.l3_base[35:20]};
				OFS_NULL_COUNT: s_next.mmio_rdata = s_reg.null_count;
				OFS_BYPASS: s_next.mmio_rdata = {31'h0, s_reg.bypass_off};
				default: s_next.mmio_rdata = 32'h0;
			endcase
			if (mmio.write) begin
				case (mmio.addr)
					OFS_NULL_MATCH: s_next.null_val = mmio.wdata;
					OFS_INV_MATCH: s_next.inv_val = mmio.wdata;
					OFS_ADDR_DETECT: s_next.detect = mmio.wdata[7:0];
					OFS_CONTROL: s_next.ctl = mmio.wdata[1:0];
					OFS_L3_BASE_LO: s_next.l3_base[19:0] = mmio.wdata[31:12];
					OFS_L3_BASE_HI: s_next.l3_base[35:20] = mmio.wdata[15:0];
					OFS_BYPASS: s_next.bypass_off = mmio.wdata[BYPASS_OFF_BIT];
					default: s_next.mmio_ack = 1'b1;
				endcase
			end
		end

		if (s_reg.fetch.valid && fetch_ready) begin
			s_next.fetch.valid = 1'b0;
		end

		case (s_reg.st)
			ST_IDLE: begin
				if (req_valid && s_reg.req_ready) begin
					s_next.addr = req.addr;
					s_next.write = req.write;
					if (active && hit) begin
						s_next.st = ST_L3;
						s_next.req_ready = 1'b0;
						s_next.fetch.valid = 1'b1;
						s_next.fetch.virt = 1'b1;
						s_next.fetch.addr = {s_reg.l3_base, req.addr[43:35], 3'h0};
					end else begin
						s_next.resp.valid = 1'b1;
						s_next.resp.kind = KIND_PASS;
						s_next.resp.addr = req.addr;
						s_next.resp.zero_data = 1'b0;
						s_next.resp.null_ind = 1'b0;
						s_next.resp.drop = 1'b0;
					end
				end
			end
			ST_L3, ST_L2, ST_L1: begin
				// Fetch faults resolve in the main walker; data taken as-is
				if (got) begin
					s_next.resp.addr = s_reg.addr;
					s_next.resp.zero_data = 1'b0;
					s_next.resp.null_ind = 1'b0;
					s_next.resp.drop = 1'b0;
					if (cls_inv || cls_null) begin
						s_next.st = ST_IDLE;
						s_next.req_ready = 1'b1;
						s_next.resp.valid = 1'b1;
						s_next.resp.zero_data = !s_reg.write;
						s_next.resp.drop = s_reg.write;
						s_next.resp.null_ind = cls_null && !s_reg.write;
						if (cls_inv) begin
							s_next.resp.kind = KIND_INVALID;
							s_next.irq = 1'b1;
						end else begin
							s_next.resp.kind = KIND_NULL;
							s_next.null_count = s_reg.null_count + 32'h1;
						end
					end else if (leaf) begin
						s_next.st = ST_IDLE;
						s_next.req_ready = 1'b1;
						s_next.resp.valid = 1'b1;
						s_next.resp.kind = KIND_MAPPED;
						s_next.resp.addr = {entry[31:0], s_reg.addr[15:0]};
					end else begin
						// Each level fetch may itself take a nested walk
						s_next.fetch.valid = 1'b1;
						if (s_reg.st == ST_L3) begin
							s_next.st = ST_L2;
							s_next.fetch.addr = {fetch_rdata[47:12],
								s_reg.addr[34:26], 3'h0};
						end else begin
							s_next.st = ST_L1;
							s_next.fetch.addr = {fetch_rdata[47:12],
								s_reg.addr[25:16], 2'h0};
						end
					end
				end
			end
			default: begin
				s_next.st = ST_IDLE;
				s_next.req_ready = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.null_val <= RST_MATCH;
			s_reg.inv_val <= RST_MATCH;
			s_reg.detect <= RST_DETECT;
			s_reg.ctl <= RST_CONTROL;
			s_reg.l3_base <= RST_L3_BASE;
			s_reg.null_count <= RST_COUNT;
			s_reg.req_ready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign req_ready = s_reg.req_ready;
	assign resp = s_reg.resp;
	assign tile_fault_irq = s_reg.irq;
	assign fetch = s_reg.fetch;
	assign mmio_ack = s_reg.mmio_ack;
	assign mmio_rdata = s_reg.mmio_rdata;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_take;
		req_valid && req_ready;
	endsequence

	sequence s_pass_answer;
		resp.valid && resp.kind == KIND_PASS && resp.addr == $past(req.addr);
	endsequence

	property p_disabled_pass;
		@(posedge clk_sys) disable iff (!rst_b)
		s_take and (!s_reg.ctl[CTL_EN_BIT]) |=> s_pass_answer;
	endproperty
	a_disabled_pass: assert property (p_disabled_pass)
		else $error("Request not passed while disabled");

	property p_bypass_pass;
		@(posedge clk_sys) disable iff (!rst_b)
		s_take and (!s_reg.bypass_off) |=> s_pass_answer;
	endproperty
	a_bypass_pass: assert property (p_bypass_pass)
		else $error("Request not passed while bypassed");

	property p_mask_off_pass;
		@(posedge clk_sys) disable iff (!rst_b)
		s_take and (s_reg.detect[7:4] == 4'h0) |=> s_pass_answer;
	endproperty
	a_mask_off_pass: assert property (p_mask_off_pass)
		else $error("Detection active with zero mask");

	property p_detect_walk;
		@(posedge clk_sys) disable iff (!rst_b)
		s_take and active && s_reg.detect[7:4] == 4'hf &&
			req.addr[47:44] == s_reg.detect[3:0]
		|=> fetch.valid && !resp.valid && s_reg.st == ST_L3;
	endproperty
	a_detect_walk: assert property (p_detect_walk)
		else $error("Tiled address did not start a walk");

	property p_upper_null_stops;
		@(posedge clk_sys) disable iff (!rst_b)
		got && !leaf && fetch_rdata[1:0] == 2'h2
		|=> resp.valid && resp.kind == KIND_NULL && !fetch.valid;
	endproperty
	a_upper_null_stops: assert property (p_upper_null_stops)
		else $error("Upper null flag did not end the walk");

	property p_leaf_null;
		@(posedge clk_sys) disable iff (!rst_b)
		got && leaf && entry[31:0] == s_reg.null_val &&
			entry[31:0] != s_reg.inv_val
		|=> resp.valid && resp.kind == KIND_NULL;
	endproperty
	a_leaf_null: assert property (p_leaf_null)
		else $error("Null match value not honoured");

	property p_irq_invalid;
		@(posedge clk_sys) disable iff (!rst_b)
		tile_fault_irq == (resp.valid && resp.kind == KIND_INVALID);
	endproperty
	a_irq_invalid: assert property (p_irq_invalid)
		else $error("Interrupt not tied to invalid answer");

	property p_null_count;
		@(posedge clk_sys) disable iff (!rst_b)
		resp.valid && resp.kind == KIND_NULL
		|-> s_reg.null_count == $past(s_reg.null_count) + 32'h1;
	endproperty
	a_null_count: assert property (p_null_count)
		else $error("Null counter did not step by one");

	property p_store_dropped;
		@(posedge clk_sys) disable iff (!rst_b)
		resp.valid && resp.kind inside {KIND_NULL, KIND_INVALID}
		|-> resp.drop == s_reg.write && resp.zero_data == !s_reg.write;
	endproperty
	a_store_dropped: assert property (p_store_dropped)
		else $error("Null access answered wrongly");

endmodule : trw_walker

`default_nettype wire

// >>> verif/trw_mem_model.sv
/*
 Model of the main page walker serving tile table fetches.
 Assumes clk_sys is shared; the bench fills mem by qword index.
*/
`timescale 1ns/1ns
`default_nettype none

module trw_mem_model import trw_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic slow,
	input wire trw_fetch_t fetch,
	output logic fetch_ready,
	output logic fetch_rvalid,
	output logic [63:0] fetch_rdata
);
	logic [63:0] mem [logic [44:0]];
	logic [44:0] idx;

	initial begin
		fetch_ready = 1'b0;
		fetch_rvalid = 1'b0;
		fetch_rdata = 64'h0;
	end

	// ------------------------------------------------------------
	// Accept, then return the qword; faults never surface here
	// ------------------------------------------------------------
	always begin
		@(posedge clk_sys);
		if (rst_b && fetch.valid) begin
			repeat (slow ? 3 : 0) @(posedge clk_sys);
			@(negedge clk_sys);
			fetch_ready = 1'b1;
			idx = fetch.addr[47:3];
			@(posedge clk_sys);
			@(negedge clk_sys);
			fetch_ready = 1'b0;
			repeat (slow ? 4 : 1) @(posedge clk_sys);
			@(negedge clk_sys);
			fetch_rvalid = 1'b1;
			fetch_rdata = mem.exists(idx) ? mem[idx] : 64'h0;
			@(posedge clk_sys);
			@(negedge clk_sys);
			fetch_rvalid = 1'b0;
			fetch_rdata = ~fetch_rdata;
		end
	end
endmodule : trw_mem_model

`default_nettype wire

// >>> verif/trw_walker_test.sv
/*
 Self-checking bench of the tile walker with a reference model.
 Assumes the page walker model in trw_mem_model and one 250 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %h got %h", n, e, s); end end

module trw_walker_test import trw_pkg::*;;
	logic clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, slow = 1'b0;
	logic req_ready, irq, fr, frv, ack;
	trw_req_t req = '0;
	trw_resp_t resp;
	trw_fetch_t fetch;
	trw_mmio_req_t mmio = '0;
	logic [63:0] frd;
	logic [31:0] rdata;
	logic [31:0] regs [logic [15:0]];
	int n_errors = 0, cmp_count = 0, nulls = 0;
	integer seed = 32'h91219c1b;

	trw_walker i_trw_walker (.clk_sys(clk_sys), .rst_b(rst_b),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.resp(resp), .tile_fault_irq(irq), .fetch(fetch),
		.fetch_ready(fr), .fetch_rvalid(frv), .fetch_rdata(frd),
		.mmio(mmio), .mmio_ack(ack), .mmio_rdata(rdata));

	trw_mem_model i_trw_mem_model (.clk_sys(clk_sys), .rst_b(rst_b),
		.slow(slow), .fetch(fetch), .fetch_ready(fr),
		.fetch_rvalid(frv), .fetch_rdata(frd));

	always #2 clk_sys = ~clk_sys;

	always @(negedge clk_sys) if (fetch.valid) `CHK("virt", 1'b1, fetch.virt)

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	function automatic logic [31:0] rd_exp(input logic [15:0] a);
		logic [31:0] m;
		case (a)
			OFS_NULL_MATCH, OFS_INV_MATCH: m = 32'hffffffff;
			OFS_ADDR_DETECT: m = 32'h000000ff;
			OFS_CONTROL: m = 32'h00000003;
			OFS_L3_BASE_LO: m = 32'hfffff000;
			OFS_L3_BASE_HI: m = 32'h0000ffff;
			OFS_BYPASS: m = 32'h00000001;
			default: m = 32'h0;
		endcase
		if (a == OFS_NULL_COUNT) return nulls[31:0];
		return regs.exists(a) ? regs[a] & m : 32'h0;
	endfunction : rd_exp

	function automatic logic [47:0] first(input logic [47:0] a);
		logic [31:0] hi, lo;
		hi = rd_exp(OFS_L3_BASE_HI);
		lo = rd_exp(OFS_L3_BASE_LO);
		return {hi[15:0], lo[31:12], a[43:35], 3'h0};
	endfunction : first

	function automatic logic [63:0] qw(input logic [47:0] f);
		if (i_trw_mem_model.mem.exists(f[47:3]))
			return i_trw_mem_model.mem[f[47:3]];
		return 64'h0;
	endfunction : qw

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic mmio_op(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(negedge clk_sys);
		mmio = '{1'b1, w, a, d};
		@(negedge clk_sys);
		mmio.valid = 1'b0;
		`CHK("mmio_ack", 1'b1, ack)
		q = rdata;
		if (w) regs[a] = d;
	endtask : mmio_op

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		mmio_op(1'b1, a, d, q);
	endtask : wr

	task automatic do_req(input logic [47:0] a, input logic w);
		logic [31:0] det, ctl, byp, l1;
		logic [47:0] f, ea;
		logic [63:0] e;
		trw_kind_t k;
		trw_resp_t x;
		int i;
		det = rd_exp(OFS_ADDR_DETECT);
		ctl = rd_exp(OFS_CONTROL);
		byp = rd_exp(OFS_BYPASS);
		k = KIND_PASS;
		ea = a;
		if (ctl[0] && byp[0] && det[7:4] != 4'h0
			&& ((a[47:44] ^ det[3:0]) & det[7:4]) == 4'h0) begin
			k = KIND_MAPPED;
			f = first(a);
			for (i = 0; i < 2 && k == KIND_MAPPED; i++) begin
				e = qw(f);
				if (e[0]) k = KIND_INVALID;
				else if (e[1]) k = KIND_NULL;
				f = i == 0 ? {e[47:12], a[34:26], 3'h0}
					: {e[47:12], a[25:16], 2'h0};
			end
			if (k == KIND_MAPPED) begin
				e = qw(f);
				l1 = f[2] ? e[63:32] : e[31:0];
				if (l1 == rd_exp(OFS_INV_MATCH)) k = KIND_INVALID;
				else if (l1 == rd_exp(OFS_NULL_MATCH)) k = KIND_NULL;
				else ea = {l1, a[15:0]};
			end
		end
		x = '{1'b1, k, ea, k[1] && !w, k == KIND_NULL && !w, k[1] && w};
		@(negedge clk_sys);
		req_valid = 1'b1;
		req = '{a, w};
		for (i = 0; req_ready !== 1'b1 && i < 60; i++) @(negedge clk_sys);
		@(negedge clk_sys);
		req_valid = 1'b0;
		for (i = 0; resp.valid !== 1'b1 && i < 60; i++) @(negedge clk_sys);
		`CHK("resp", x, resp)
		`CHK("irq", k == KIND_INVALID, irq)
		`CHK("ready", 1'b1, req_ready)
		if (k == KIND_NULL) nulls++;
	endtask : do_req

	task automatic walk_one(input logic w, input logic [3:0] top);
		logic [47:0] a, f;
		logic [63:0] e;
		logic [31:0] l1;
		int j;
		a = {top, 12'($random(seed)), 32'($random(seed))};
		f = first(a);
		for (j = 0; j < 3; j++) begin
			e = {$random(seed), $random(seed)};
			if (j < 2) e[1:0] = e[5:3] == 3'h0 ? e[7:6] : 2'h0;
			else if (e[9]) begin
				l1 = rd_exp(e[8] ? OFS_NULL_MATCH : OFS_INV_MATCH);
				if (f[2]) e[63:32] = l1;
				else e[31:0] = l1;
			end
			i_trw_mem_model.mem[f[47:3]] = e;
			f = j == 0 ? {e[47:12], a[34:26], 3'h0}
				: {e[47:12], a[25:16], 2'h0};
		end
		do_req(a, w);
	endtask : walk_one

	task automatic stop_test();
		if (n_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end

	initial begin
		logic [15:0] ofs [9];
		logic [31:0] q, r;
		int j;
		ofs = '{OFS_NULL_MATCH, OFS_INV_MATCH, OFS_ADDR_DETECT, OFS_CONTROL,
			OFS_L3_BASE_LO, OFS_L3_BASE_HI, OFS_NULL_COUNT, OFS_BYPASS,
			16'h4e00};
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		do_req({$random(seed), 16'h0}, 1'b0);
		foreach (ofs[j]) begin
			mmio_op(1'b0, ofs[j], 32'h0, q);
			`CHK("reg_reset", 32'h0, q)
			wr(ofs[j], $random(seed));
			mmio_op(1'b0, ofs[j], 32'h0, q);
			`CHK("reg_rw", rd_exp(ofs[j]), q)
		end
		r = $random(seed);
		wr(OFS_NULL_MATCH, r);
		wr(OFS_INV_MATCH, ~r);
		wr(OFS_ADDR_DETECT, 32'h000000f9);
		wr(OFS_CONTROL, 32'h00000003);
		wr(OFS_BYPASS, 32'h00000001);
		for (j = 0; j < 40; j++) begin
			slow = j[0];
			walk_one(j[1], 4'h9);
		end
		for (j = 0; j < 8; j++) begin
			r = $random(seed);
			wr(OFS_ADDR_DETECT, {24'h0, {4{j[0]}}, r[3:0]});
			wr(OFS_CONTROL, {30'h0, 1'b1, j[1]});
			wr(OFS_BYPASS, {31'h0, j[2]});
			walk_one(r[9], r[8] ? r[3:0] : r[7:4]);
		end
		mmio_op(1'b0, OFS_NULL_COUNT, 32'h0, q);
		`CHK("null_count", nulls[31:0], q)
		stop_test();
	end
endmodule : trw_walker_test

`default_nettype wire
